// *** idle_cpu_model.sv ***
// CPU-side model: keeps port and bus values moving and returns from the NMI handler.
// Assumes the sequencer's clock and reset; outputs change just after the rising edge.
`timescale 1ns/1ns
module idle_cpu_model (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       in_nmi_handler,
	input  wire logic       irq_resume,
	output logic            return_from_irq_instr,
	output logic [7:0]      port_latch_in,
	output logic [7:0]      cpu_low_addr,
	output logic            cpu_bus_active
);
	logic [2:0] ret_wait_q;

	// Core keeps rewriting its latch so a freeze in idle is visible
	always_ff @(posedge clk) begin
		if (!rstn) begin
			port_latch_in <= 8'h00;
		end else begin
			port_latch_in <= port_latch_in + 8'h01;
		end
	end
	assign cpu_low_addr = ~port_latch_in;
	assign cpu_bus_active = port_latch_in[0];

	// Handler finishes a few cycles after resuming, then returns
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ret_wait_q <= 3'h0;
		end else if (irq_resume && in_nmi_handler) begin
			ret_wait_q <= 3'h4;
		end else if (ret_wait_q != 3'h0) begin
			ret_wait_q <= ret_wait_q - 3'h1;
		end
	end
	assign return_from_irq_instr = (ret_wait_q == 3'h1);
endmodule

// *** idle_standby_chk.sv ***
// Assertions on the IDLE standby sequencer ports, bound to its top module.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ns
`include "idle_standby_params.svh"
module idle_standby_chk
	import idle_standby_pkg::*;
(
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       main_osc_en,
	input wire logic       sub_osc_en,
	input wire logic       cpu_clk_en,
	input wire logic       periph_clk_en,
	input wire logic       i2c_run_en,
	input wire logic [7:0] port_latch_out,
	input wire logic [7:0] low_addr_lines,
	input wire logic       low_addr_oe_n,
	input wire logic       muxed_addr_data_oe_n,
	input wire logic       high_addr_oe_n,
	input wire logic       addr_latch_strobe_oe_n,
	input wire logic       rd_wr_wait_oe_n,
	input wire logic       irq_vector,
	input wire logic       irq_resume,
	input wire logic       irq_acceptable,
	input wire logic       global_irq_enable_flag,
	input wire logic       other_irq_req,
	input wire logic       pend_other_irq
);
	logic idle;

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// Fully parked: CPU clock gated and main oscillator stopped
	assign idle = !cpu_clk_en && !main_osc_en;

	a_entry_gates: assert property (
		reg_wr && reg_addr == `REG_STBY_CTRL && reg_wdata == `STBY_IDLE_CODE && cpu_clk_en
		|=> !cpu_clk_en && !periph_clk_en && !main_osc_en && sub_osc_en) else $error("entry left clocks on");
	a_park_addr: assert property (
		idle |-> low_addr_lines == `STBY_PARK_ADDR && !low_addr_oe_n) else $error("low address not parked");
	a_float_bus: assert property (
		idle |-> muxed_addr_data_oe_n && high_addr_oe_n && addr_latch_strobe_oe_n && rd_wr_wait_oe_n)
		else $error("bus pin driven in idle");
	a_latch_hold: assert property (
		idle ##1 idle |-> $stable(port_latch_out)) else $error("port latch moved in idle");
	a_i2c_stop: assert property (
		idle |-> !i2c_run_en) else $error("i2c running in idle");
	a_vec_accept: assert property (
		irq_vector |-> $past(irq_acceptable, 2) && $past(global_irq_enable_flag, 2))
		else $error("vector without acceptance");
	a_pulse_excl: assert property (
		irq_vector || irq_resume |-> !(irq_vector && irq_resume) ##1 !irq_vector && !irq_resume)
		else $error("exit pulse wrong");
	a_pend_other: assert property (
		idle && other_irq_req ##1 idle |-> pend_other_irq) else $error("other request not pended");

	c_enter: cover property ($fell(cpu_clk_en));
	c_vector: cover property (irq_vector);
	c_resume: cover property (irq_resume);
endmodule

bind idle_standby_controller idle_standby_chk u_chk (.*);

// *** idle_standby_controller.sv ***
// IDLE standby sequencer: entry by control code, clock gating, bus parking and wake-up.
// Assumes one 250 MHz clock, synchronous inputs and a plain single-cycle register port.
//
// How it works
// - IDLE stops main oscillator, keeps subsystem clock, gates CPU and peripheral clocks.
// - Port output latches hold their pre-IDLE values throughout IDLE.
// - Watch timer counts in IDLE only when fed from the subsystem clock.
// - 16-bit timer runs only on watch timer output clocked from subsystem clock.
// - Each 8-bit timer pair runs only from its external timer input.
// - Real-time output runs only on external trigger or timers 1-2 external.
// - Serial runs only on external clock; I2C mode stops in IDLE.
// - Low address lines drive C0H; other bus pins float in IDLE.
// - Only NMI, pin, watch timer and key-return interrupts release; others stay pending.
// - A valid NMI edge per the edge enable registers releases IDLE.
// - NMI release vectors unless taken inside the NMI handler, else resumes until return-from-interrupt.
// - Unmasked pin interrupt without macro service releases on its valid edge.
// - Unmasked watch timer interrupt without macro service releases on overflow.
// - Unmasked key-return falling edge without macro service releases IDLE.
// - Maskable release vectors when enable flag is 1 and acceptable, else resumes.
// - A reset that ends IDLE keeps data memory contents intact.
`timescale 1ns/1ns
module idle_standby_controller
	import idle_standby_pkg::*;
#(
	parameter int NUM_PINS = 7,
	parameter int NUM_KEYS = 8,
	parameter int PORT_W   = 8
) (
	// Clock, reset and register port
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire logic [3:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic [7:0]               reg_rdata,
	// Wake sources with their masks and macro-service selects
	input  wire logic                nmi_pin,
	input  wire logic [NUM_PINS-1:0] ext_pin_irqs,
	input  wire logic [NUM_PINS-1:0] pin_irq_mask,
	input  wire logic [NUM_PINS-1:0] pin_macro_svc,
	input  wire logic                watch_timer_irq,
	input  wire logic                wt_irq_mask,
	input  wire logic                wt_macro_svc,
	input  wire logic [NUM_KEYS-1:0] key_return_pins,
	input  wire logic                key_irq_mask,
	input  wire logic                key_macro_svc,
	// Core interrupt state
	input  wire logic                other_irq_req,
	input  wire logic                global_irq_enable_flag,
	input  wire logic                irq_acceptable,
	input  wire logic                in_nmi_handler,
	input  wire logic                return_from_irq_instr,
	// Core values carried through outside IDLE
	input  wire logic [PORT_W-1:0]   port_latch_in,
	input  wire logic [7:0]          cpu_low_addr,
	input  wire logic                cpu_bus_active,
	// Oscillator, clock and peripheral run enables
	output logic                     main_osc_en,
	output logic                     sub_osc_en,
	output logic                     cpu_clk_en,
	output logic                     periph_clk_en,
	output logic                     wt_run_en,
	output logic                     t16_run_en,
	output logic [2:0]               t8_pair_run_en,
	output logic                     rto_run_en,
	output logic                     serial_run_en,
	output logic                     i2c_run_en,
	// Held port latches and parked bus pins
	output logic [PORT_W-1:0]        port_latch_out,
	output logic [7:0]               low_addr_lines,
	output logic                     low_addr_oe_n,
	output logic                     muxed_addr_data_oe_n,
	output logic                     high_addr_oe_n,
	output logic                     addr_latch_strobe_oe_n,
	output logic                     rd_wr_wait_oe_n,
	// Exit reports, pending marker and interrupt
	output logic                     irq_vector,
	output logic                     irq_vector_nmi,
	output logic                     irq_resume,
	output logic                     pend_other_irq,
	output logic                     ram_retain,
	output logic                     irq
);
	// Sequencer and register state
	idle_state_e                 state_q;
	exit_kind_e                  exit_q;
	logic [7:0]                  stby_ctrl_q;
	logic [7:0]                  rise_en_q;
	logic [7:0]                  fall_en_q;
	logic [7:0]                  src_cfg_q;
	logic [`EV_COUNT-1:0]        irq_stat_q;
	logic [`EV_COUNT-1:0]        irq_en_q;
	logic [NUM_PINS:0]           edge_prev_q;
	logic [NUM_KEYS-1:0]         key_prev_q;
	logic                        wt_prev_q;
	logic                        nmi_deferred_q;
	logic                        was_idle_q;
	logic                        nmi_exit_q;
	logic                        rst_prev_q;
	// Decoded edges and release requests
	logic [NUM_PINS:0]           edge_in;
	logic [NUM_PINS:0]           edge_hit;
	logic                        nmi_rel;
	logic                        pin_rel;
	logic                        wt_rel;
	logic                        key_rel;
	logic                        enter;
	logic [`EV_COUNT-1:0]        ev;
	logic                        in_idle;

	// Edge-selectable sources: pin interrupts in low bits, NMI on top
	assign edge_in = {nmi_pin, ext_pin_irqs};
	generate
		for (genvar i = 0; i <= NUM_PINS; i++) begin : g_edge
			assign edge_hit[i] = (rise_en_q[i] & edge_in[i] & ~edge_prev_q[i]) |
				(fall_en_q[i] & ~edge_in[i] & edge_prev_q[i]);
		end
	endgenerate

	// Release sources; other requests never wake the block
	// Masked or macro-serviced sources stay asleep; edges are judged against last cycle
	assign in_idle = (state_q == ST_IDLE);
	assign nmi_rel = in_idle & edge_hit[`NMI_BIT];
	assign pin_rel = in_idle & |(edge_hit[NUM_PINS-1:0] & ~pin_irq_mask & ~pin_macro_svc);
	assign wt_rel  = in_idle & watch_timer_irq & ~wt_prev_q & ~wt_irq_mask & ~wt_macro_svc;
	assign key_rel = in_idle & ~key_irq_mask & ~key_macro_svc &
		|(~key_return_pins & key_prev_q);
	assign enter   = reg_wr & (reg_addr == `REG_STBY_CTRL) &
		(reg_wdata == `STBY_IDLE_CODE) & (state_q == ST_RUN);
	assign ev      = {key_rel, wt_rel, pin_rel, nmi_rel, enter};

	// Input history for edge detection
	always_ff @(posedge clk) begin
		if (!rstn) begin
			edge_prev_q <= '0;
			key_prev_q  <= '1;
			wt_prev_q   <= 1'b0;
		end else begin
			edge_prev_q <= edge_in;
			key_prev_q  <= key_return_pins;
			wt_prev_q   <= watch_timer_irq;
		end
	end

	// Sequencer state
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q <= ST_RUN;
		end else begin
			case (state_q)
				ST_RUN: begin
					if (enter) begin
						state_q <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (nmi_rel | pin_rel | wt_rel | key_rel) begin
						state_q <= ST_WAKE;
					end
				end
				ST_WAKE: begin
					state_q <= ST_RUN;
				end
				default: begin
					state_q <= ST_RUN;
				end
			endcase
		end
	end

	// Exit decision and deferred NMI
	// An NMI taken inside its own handler resumes first and vectors after the return
	always_ff @(posedge clk) begin
		if (!rstn) begin
			exit_q         <= EXIT_NONE;
			nmi_exit_q     <= 1'b0;
			nmi_deferred_q <= 1'b0;
		end else begin
			exit_q     <= EXIT_NONE;
			nmi_exit_q <= nmi_rel;
			if (nmi_rel) begin
				if (in_nmi_handler) begin
					exit_q         <= EXIT_RESUME;
					nmi_deferred_q <= 1'b1;
				end else begin
					exit_q <= EXIT_VECTOR;
				end
			end else if (pin_rel | wt_rel | key_rel) begin
				if (global_irq_enable_flag & irq_acceptable) begin
					exit_q <= EXIT_VECTOR;
				end else begin
					exit_q <= EXIT_RESUME;
				end
			end else if (nmi_deferred_q & return_from_irq_instr) begin
				nmi_deferred_q <= 1'b0;
			end
		end
	end

	// Exit pulses to the core
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_vector     <= 1'b0;
			irq_vector_nmi <= 1'b0;
			irq_resume     <= 1'b0;
		end else begin
			irq_vector     <= (exit_q == EXIT_VECTOR) & ~nmi_exit_q;
			irq_resume     <= (exit_q == EXIT_RESUME);
			irq_vector_nmi <= ((exit_q == EXIT_VECTOR) & nmi_exit_q) |
				(nmi_deferred_q & return_from_irq_instr & ~nmi_rel);
		end
	end

	// Clock, peripheral and pending controls
	always_ff @(posedge clk) begin
		if (!rstn) begin
			main_osc_en    <= 1'b1;
			sub_osc_en     <= 1'b1;
			cpu_clk_en     <= 1'b1;
			periph_clk_en  <= 1'b1;
			wt_run_en      <= 1'b1;
			t16_run_en     <= 1'b1;
			t8_pair_run_en <= '1;
			rto_run_en     <= 1'b1;
			serial_run_en  <= 1'b1;
			i2c_run_en     <= 1'b1;
			pend_other_irq <= 1'b0;
		end else begin
			main_osc_en   <= ((state_q != ST_IDLE) & ~enter) | (|ev[`EV_COUNT-1:1]);
			sub_osc_en    <= 1'b1;
			cpu_clk_en    <= (state_q != ST_IDLE) & ~enter;
			periph_clk_en <= (state_q != ST_IDLE) & ~enter;
			// Run enables follow the count-source setup only while idle
			if ((state_q == ST_IDLE) | enter) begin
				wt_run_en         <= src_cfg_q[`CFG_WT_SUB];
				t16_run_en        <= src_cfg_q[`CFG_T16_WT] & src_cfg_q[`CFG_WT_SUB];
				t8_pair_run_en[0] <= src_cfg_q[`CFG_T12_EXT];
				t8_pair_run_en[1] <= src_cfg_q[`CFG_T56_EXT];
				t8_pair_run_en[2] <= src_cfg_q[`CFG_T78_EXT];
				rto_run_en        <= src_cfg_q[`CFG_RTO_EXT] | src_cfg_q[`CFG_T12_EXT];
				serial_run_en     <= src_cfg_q[`CFG_SER_EXT] & ~src_cfg_q[`CFG_I2C];
				i2c_run_en        <= 1'b0;
			end else begin
				wt_run_en      <= 1'b1;
				t16_run_en     <= 1'b1;
				t8_pair_run_en <= '1;
				rto_run_en     <= 1'b1;
				serial_run_en  <= 1'b1;
				i2c_run_en     <= 1'b1;
			end
			pend_other_irq <= other_irq_req & ((state_q == ST_IDLE) | enter);
		end
	end

	// Port latches frozen and bus pins parked while idle
	always_ff @(posedge clk) begin
		if (!rstn) begin
			port_latch_out         <= '0;
			low_addr_lines         <= '0;
			low_addr_oe_n          <= 1'b1;
			muxed_addr_data_oe_n   <= 1'b1;
			high_addr_oe_n         <= 1'b1;
			addr_latch_strobe_oe_n <= 1'b1;
			rd_wr_wait_oe_n        <= 1'b1;
		end else if ((state_q == ST_IDLE) | enter) begin
			low_addr_lines         <= `STBY_PARK_ADDR;
			low_addr_oe_n          <= 1'b0;
			muxed_addr_data_oe_n   <= 1'b1;
			high_addr_oe_n         <= 1'b1;
			addr_latch_strobe_oe_n <= 1'b1;
			rd_wr_wait_oe_n        <= 1'b1;
		end else begin
			port_latch_out         <= port_latch_in;
			low_addr_lines         <= cpu_low_addr;
			low_addr_oe_n          <= ~cpu_bus_active;
			muxed_addr_data_oe_n   <= ~cpu_bus_active;
			high_addr_oe_n         <= ~cpu_bus_active;
			addr_latch_strobe_oe_n <= ~cpu_bus_active;
			rd_wr_wait_oe_n        <= ~cpu_bus_active;
		end
	end

	// Reset seen last cycle; marks the first cycle after a release
	always_ff @(posedge clk) begin
		rst_prev_q <= ~rstn;
	end

	// Standby marker; not cleared by reset so it survives the reset that ends IDLE
	always_ff @(posedge clk) begin
		if (rstn) begin
			was_idle_q <= (state_q == ST_IDLE) | enter;
		end
	end

	// Retention flag: set by a reset that ended IDLE, cleared at the next entry
	// A normal wake leaves it clear; the marker is undefined until the first release
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ram_retain <= 1'b0;
		end else if (rst_prev_q && was_idle_q) begin
			ram_retain <= 1'b1;
		end else if (enter) begin
			ram_retain <= 1'b0;
		end
	end

	// Writable registers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			stby_ctrl_q <= `STBY_CTRL_RESET;
			rise_en_q   <= '0;
			fall_en_q   <= '0;
			src_cfg_q   <= '0;
			irq_en_q    <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
				`REG_STBY_CTRL: stby_ctrl_q <= reg_wdata;
				`REG_RISE_EN:   rise_en_q   <= reg_wdata;
				`REG_FALL_EN:   fall_en_q   <= reg_wdata;
				`REG_SRC_CFG:   src_cfg_q   <= reg_wdata;
				`REG_IRQ_EN:    irq_en_q    <= reg_wdata[`EV_COUNT-1:0];
				default: begin
				end
			endcase
		end else if (state_q == ST_WAKE) begin
			stby_ctrl_q <= `STBY_CTRL_RESET;
		end
	end

	// Sticky event status; a new event wins over a clear
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q &
				~((reg_wr && reg_addr == `REG_IRQ_CLR) ? reg_wdata[`EV_COUNT-1:0] : '0)) | ev;
		end
	end

	// Level interrupt from enabled sticky bits
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_q & irq_en_q);
		end
	end

	// Read port, data one cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				`REG_STBY_CTRL: reg_rdata <= stby_ctrl_q;
				`REG_STATUS:    reg_rdata <= {5'h00, nmi_deferred_q, state_q};
				`REG_IRQ_STAT:  reg_rdata <= {3'h0, irq_stat_q};
				`REG_IRQ_EN:    reg_rdata <= {3'h0, irq_en_q};
				`REG_RISE_EN:   reg_rdata <= rise_en_q;
				`REG_FALL_EN:   reg_rdata <= fall_en_q;
				`REG_SRC_CFG:   reg_rdata <= src_cfg_q;
				default:        reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule

// *** idle_standby_params.svh ***
// Constants for the IDLE standby sequencer.
// Included by the package, the checker and the bench; definitions only.
`ifndef IDLE_STANDBY_PARAMS_SVH
`define IDLE_STANDBY_PARAMS_SVH
`define STBY_IDLE_CODE    8'h47
`define STBY_CTRL_RESET   8'h00
`define STBY_PARK_ADDR    8'hC0
`define REG_STBY_CTRL     4'h0
`define REG_STATUS        4'h1
`define REG_IRQ_STAT      4'h2
`define REG_IRQ_EN        4'h3
`define REG_IRQ_CLR       4'h4
`define REG_RISE_EN       4'h5
`define REG_FALL_EN       4'h6
`define REG_SRC_CFG       4'h7
`define EV_ENTER          0
`define EV_REL_NMI        1
`define EV_REL_PIN        2
`define EV_REL_WT         3
`define EV_REL_KEY        4
`define EV_COUNT          5
`define CFG_WT_SUB        0
`define CFG_T16_WT        1
`define CFG_T12_EXT       2
`define CFG_T56_EXT       3
`define CFG_T78_EXT       4
`define CFG_RTO_EXT       5
`define CFG_SER_EXT       6
`define CFG_I2C           7
`define NMI_BIT           7
`endif

// *** idle_standby_pkg.sv ***
// Types shared by the IDLE standby sequencer.
// Assumes idle_standby_params.svh is in the include path.
`include "idle_standby_params.svh"
package idle_standby_pkg;
	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_IDLE = 2'b01,
		ST_WAKE = 2'b10
	} idle_state_e;
	typedef enum logic [1:0] {
		EXIT_NONE   = 2'b00,
		EXIT_VECTOR = 2'b01,
		EXIT_RESUME = 2'b10
	} exit_kind_e;
endpackage

// *** test_idle_standby_controller.sv ***
// Self-checking bench for the IDLE standby sequencer.
// Assumes the sequencer, its package, checker and CPU model are compiled first.
`timescale 1ns/1ns
`include "idle_standby_params.svh"
module test_idle_standby_controller
	import idle_standby_pkg::*;
;
	typedef struct packed {
		logic [1:0] src;
		logic       ie;
		logic       acc;
		logic [7:0] cfg;
		logic [2:0] ex;
	} row_s;
	localparam int STAB = 6;

	logic       clk, rstn, reg_wr, reg_rd, nmi_pin, watch_timer_irq, wt_irq_mask, wt_macro_svc;
	logic       key_irq_mask, key_macro_svc, other_irq_req, global_irq_enable_flag, irq_acceptable;
	logic       in_nmi_handler, return_from_irq_instr, cpu_bus_active, main_osc_en, sub_osc_en;
	logic       cpu_clk_en, periph_clk_en, wt_run_en, t16_run_en, rto_run_en, serial_run_en, i2c_run_en;
	logic       low_addr_oe_n, muxed_addr_data_oe_n, high_addr_oe_n, addr_latch_strobe_oe_n, rd_wr_wait_oe_n;
	logic       irq_vector, irq_vector_nmi, irq_resume, pend_other_irq, ram_retain, irq;
	logic [2:0] t8_pair_run_en, seen;
	logic [3:0] reg_addr;
	logic [6:0] ext_pin_irqs, pin_irq_mask, pin_macro_svc;
	logic [7:0] reg_wdata, reg_rdata, key_return_pins, port_latch_in, cpu_low_addr, port_latch_out, low_addr_lines;
	logic [7:0] held;
	int         n_mismatch, checks_done;
	row_s       rows [5];

	idle_standby_controller dut (.*);
	idle_cpu_model cpu_model (.*);

	// Free-running clock
	always #2 clk = ~clk;

	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
		checks_done++;
		if (got !== ex) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] ex);
		@(posedge clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("rdata", ex, reg_rdata);
	endtask

	// Collect exit pulses over a fixed window
	task automatic watch();
		seen = 3'h0;
		repeat (12) begin
			@(posedge clk);
			#1;
			seen = seen | {irq_vector, irq_resume, irq_vector_nmi};
		end
	endtask

	task automatic enter(input logic [7:0] c);
		wr(`REG_SRC_CFG, c);
		wr(`REG_STBY_CTRL, `STBY_IDLE_CODE);
		repeat (2) @(posedge clk);
		#1;
		chk("clocks", 8'h04, {4'h0, main_osc_en, sub_osc_en, cpu_clk_en, periph_clk_en});
		chk("low addr", `STBY_PARK_ADDR, low_addr_lines);
		chk("oe_n", 8'h0F, {3'h0, low_addr_oe_n, muxed_addr_data_oe_n, high_addr_oe_n,
			addr_latch_strobe_oe_n, rd_wr_wait_oe_n});
		chk("runs", {c[0], c[1] & c[0], c[4:2], c[5] | c[2], c[6] & ~c[7], 1'b0}, {wt_run_en, t16_run_en,
			t8_pair_run_en, rto_run_en, serial_run_en, i2c_run_en});
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Guard against a hung run
	initial begin
		#100000;
		n_mismatch++;
		wrap_up();
	end

	initial begin
		clk = 1'b0;
		{rstn, reg_wr, reg_rd, nmi_pin, watch_timer_irq, wt_irq_mask, wt_macro_svc} = '0;
		{key_irq_mask, key_macro_svc, other_irq_req, in_nmi_handler, reg_addr, reg_wdata} = '0;
		{ext_pin_irqs, pin_irq_mask, pin_macro_svc, key_return_pins} = {21'h0, 8'hFF};
		{global_irq_enable_flag, irq_acceptable} = 2'h3;
		rows = '{'{2'h0, 1'h1, 1'h1, 8'h7F, 3'h4}, '{2'h1, 1'h1, 1'h0, 8'h03, 3'h2},
			'{2'h2, 1'h1, 1'h1, 8'hC5, 3'h4}, '{2'h0, 1'h0, 1'h1, 8'h00, 3'h2},
			'{2'h3, 1'h1, 1'h1, 8'h1C, 3'h1}};
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		wr(`REG_RISE_EN, 8'hFF);
		#1;
		chk("plain reset", 8'h01, {6'h00, ram_retain, cpu_clk_en});
		// One wake source per row, maskable exit kind from enable flag and acceptance, NMI vectors
		foreach (rows[k]) begin
			{global_irq_enable_flag, irq_acceptable} <= {rows[k].ie, rows[k].acc};
			enter(rows[k].cfg);
			@(posedge clk);
			case (rows[k].src)
				2'h0: ext_pin_irqs <= 7'h01;
				2'h1: watch_timer_irq <= 1'b1;
				2'h2: key_return_pins <= 8'hF7;
				default: nmi_pin <= 1'b1;
			endcase
			watch();
			chk("exit", {5'h00, rows[k].ex}, {5'h00, seen});
			@(posedge clk);
			{ext_pin_irqs, watch_timer_irq, key_return_pins, nmi_pin} <= {8'h00, 8'hFF, 1'b0};
		end
		// Masked, macro-serviced and other requests must not wake
		wr(`REG_IRQ_CLR, 8'h1F);
		wr(`REG_IRQ_EN, 8'h01);
		{pin_irq_mask, pin_macro_svc, wt_macro_svc, key_macro_svc} <= {7'h0F, 7'h70, 2'h3};
		enter(8'h00);
		held = port_latch_out;
		@(posedge clk);
		{ext_pin_irqs, watch_timer_irq, key_return_pins, other_irq_req} <= {8'hFF, 8'h00, 1'b1};
		watch();
		chk("no exit", 8'h00, {5'h00, seen});
		chk("pend irq", 8'h03, {6'h00, pend_other_irq, irq});
		chk("latch hold", held, port_latch_out);
		@(posedge clk);
		{ext_pin_irqs, watch_timer_irq, key_return_pins, other_irq_req, key_macro_svc} <= {8'h00, 8'hFF, 2'h0};
		@(posedge clk);
		key_return_pins <= 8'h7F;
		watch();
		chk("key exit", 8'h04, {5'h00, seen});
		rd(`REG_IRQ_STAT, 8'h11);
		chk("latch run", port_latch_in - 8'h01, port_latch_out);
		wr(`REG_IRQ_CLR, 8'h01);
		rd(`REG_IRQ_STAT, 8'h10);
		chk("irq low", 8'h00, {7'h00, irq});
		rd(`REG_IRQ_EN, 8'h01);
		rd(`REG_STBY_CTRL, 8'h00);
		rd(4'hF, 8'h00);
		// Idle entered inside the NMI handler resumes, vectors after return
		in_nmi_handler <= 1'b1;
		enter(8'h00);
		@(posedge clk);
		nmi_pin <= 1'b1;
		watch();
		chk("nmi deferred", 8'h03, {5'h00, seen});
		@(posedge clk);
		{nmi_pin, in_nmi_handler} <= 2'h0;
		// Reset held through stabilisation ends idle and keeps memory
		enter(8'h7F);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (STAB) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("after reset", 8'h03, {6'h00, ram_retain, cpu_clk_en});
		wrap_up();
	end
endmodule
